// file: hdl/opc_optical_port.sv
// Optical port pin roles, inversion, carrier modulation and AHB-Lite registers
`timescale 1ns/10ps

// Functional notes
// RQ1 - With bit-bang select set the synchronised receive input is routed to the bit-bang I/O line.
// RQ2 - The duty field sets the carrier low fraction to 50, 25, 12.5 or 6.25 percent for codes 00 to 11.
// RQ3 - The receive pin is a segment when its map bit is set, else serial input or I/O per the disable bit.
// RQ4 - With receive invert set the comparator output is inverted on its way to the serial receiver.
// RQ5 - Receive inversion never affects the value seen when the receive pin is used as I/O input.
// RQ6 - The transmit select picks I/O, serial, real pulse or reactive pulse, and the map bit forces segment.
// RQ7 - With transmit invert set the optical transmit signal is inverted.
// RQ8 - Inversion is applied first and modulation acts on the inverted signal.
// RQ9 - With modulation on, every zero interval of the transmit signal is replaced by the carrier.
// RQ10 - The carrier comes from the system clock through a fixed divider set by a parameter.
module opc_optical_port #(
  parameter int CARRIER_DIV = 16              // Clock cycles per carrier period
) (
  input  wire logic                       clk,                        // System clock, 25 MHz
  input  wire logic                       rst,                        // Asynchronous reset, active high
  input  wire logic                       ce,                         // Clock enable, freezes all state
  input  wire logic                       hsel,                       // Slave select
  input  wire logic [opc_pkg::ADDR_W-1:0] haddr,                      // Byte address
  input  wire logic [1:0]                 htrans,                     // Transfer type
  input  wire logic                       hwrite,                     // Write when high
  input  wire logic [2:0]                 hsize,                      // Transfer size
  input  wire logic [31:0]                hwdata,                     // Write data
  input  wire logic                       hready,                     // Bus ready in
  output logic                            hreadyout,                  // Slave ready out
  output logic                            hresp,                      // Response, always OKAY
  output logic [31:0]                     hrdata,                     // Read data
  input  wire logic                       optical_receive_pin,        // Receive comparator output
  input  wire logic                       receive_seg_map,            // Segment map bit of receive pin
  input  wire logic                       transmit_seg_map,           // Segment map bit of transmit pin
  input  wire logic                       uart_tx_data,               // Serial transmitter output
  input  wire logic                       real_energy_pulse,          // Real energy pulse
  input  wire logic                       reactive_energy_pulse,      // Reactive energy pulse
  input  wire logic                       tx_io_data,                 // I/O data for transmit pin
  input  wire logic                       tx_io_oe,                   // I/O enable for transmit pin
  output logic                            uart_rx_data,               // To serial receiver
  output logic                            receive_pin_io_data,        // To I/O input, never inverted
  output logic                            bit_bang_io_line,           // To bit-bang I/O line
  output logic                            receive_pin_as_segment,     // Receive pin is a segment
  output logic                            receive_pin_as_io,          // Receive pin is I/O
  output logic                            transmit_pin_as_segment,    // Transmit pin is a segment
  output logic                            transmit_pin_as_io,         // Transmit pin is I/O
  output logic                            optical_transmit_pin_out,   // Transmit pin level
  output logic                            optical_transmit_pin_oe     // Transmit pin drive enable
);

  localparam int                 CNT_W     = $clog2(CARRIER_DIV);
  localparam logic [CNT_W-1:0]   CNT_LAST  = CNT_W'(CARRIER_DIV - 1);
  localparam logic [CNT_W-1:0]   CNT_ZERO  = CNT_W'(0);
  localparam logic [CNT_W-1:0]   CNT_ONE   = CNT_W'(1);
  localparam logic [CNT_W:0]     DIV_FULL  = (CNT_W+1)'(CARRIER_DIV);

  // Finest duty step is one sixteenth of a period
  initial begin
    if (CARRIER_DIV < 16 || CARRIER_DIV % 16 != 0) begin
      $error("CARRIER_DIV must be a multiple of 16");
    end
    // Keeps the divider counter to a sensible width
    if (CARRIER_DIV > 4096) begin
      $error("CARRIER_DIV above divider counter reach");
    end
    // Both register byte addresses must fit the address port
    if (opc_pkg::ADDR_W < 16) begin
      $error("ADDR_W too narrow for the register map");
    end
  end

  // ************************************************************
  // Register bus
  // ************************************************************
  opc_pkg::opc_tx_ctrl_t tx_ctrl_r;
  opc_pkg::opc_rx_ctrl_t rx_ctrl_r;
  opc_pkg::opc_aphase_t  aph_r;
  opc_pkg::opc_aphase_t  aph_nxt;
  logic                  xfer_valid;
  logic [31:0]           rdata_nxt;

  // Address phase decode, whole aligned words only
  assign xfer_valid     = hsel && hready && (htrans == opc_pkg::HTRANS_NONSEQ || htrans == opc_pkg::HTRANS_SEQ);
  assign aph_nxt.wr     = xfer_valid && hwrite;
  assign aph_nxt.tx_hit = xfer_valid && hsize == opc_pkg::HSIZE_WORD && haddr == opc_pkg::TX_CTRL_ADDR;
  assign aph_nxt.rx_hit = xfer_valid && hsize == opc_pkg::HSIZE_WORD && haddr == opc_pkg::RX_CTRL_ADDR;
  assign rdata_nxt      = aph_nxt.tx_hit ? {24'h00_0000, tx_ctrl_r} :
                          aph_nxt.rx_hit ? {24'h00_0000, rx_ctrl_r} : opc_pkg::RDATA_ZERO;
  // Stall the master while the block is frozen; unmapped addresses read zero
  assign hreadyout      = ce;
  assign hresp          = 1'b0;

  // Capture address phase and read data
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      aph_r  <= '0;
      hrdata <= opc_pkg::RDATA_ZERO;
    end else if (ce && hready) begin
      aph_r <= aph_nxt;
      // Read data stands until the next accepted read
      if (xfer_valid && !hwrite) begin
        hrdata <= rdata_nxt;
      end
    end
  end

  // Data phase write, reserved bits kept at zero
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      tx_ctrl_r <= opc_pkg::CTRL_RESET;
      rx_ctrl_r <= opc_pkg::CTRL_RESET;
    end else if (ce && aph_r.wr) begin
      if (aph_r.tx_hit) begin
        tx_ctrl_r <= opc_pkg::opc_tx_ctrl_t'({4'h0, hwdata[3:0]});
      end
      if (aph_r.rx_hit) begin
        rx_ctrl_r <= opc_pkg::opc_rx_ctrl_t'({2'h0, hwdata[5:4], 1'b0, hwdata[2:0]});
      end
    end
  end

  // ************************************************************
  // Receive path
  // ************************************************************
  logic rx_meta_r;
  logic rx_sync_r;
  logic rx_is_serial;

  // Two-stage synchroniser for the comparator output
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rx_meta_r <= 1'b0;
      rx_sync_r <= 1'b0;
    end else if (ce) begin
      rx_meta_r <= optical_receive_pin;
      rx_sync_r <= rx_meta_r;
    end
  end

  // Receive pin role decode
  assign receive_pin_as_segment = receive_seg_map;                                   // RQ3
  assign receive_pin_as_io      = !receive_seg_map && rx_ctrl_r.receive_path_disable; // RQ3
  assign rx_is_serial           = !receive_seg_map && !rx_ctrl_r.receive_path_disable;

  // Receive data outputs, inversion only on the serial path
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      uart_rx_data        <= 1'b0;
      receive_pin_io_data <= 1'b0;
      bit_bang_io_line    <= 1'b0;
    end else if (ce) begin
      uart_rx_data        <= rx_is_serial && (rx_sync_r ^ rx_ctrl_r.receive_invert); // RQ4
      receive_pin_io_data <= receive_pin_as_io && rx_sync_r;                           // RQ5
      bit_bang_io_line    <= rx_ctrl_r.bit_bang_select && rx_sync_r;                   // RQ1
    end
  end

  // ************************************************************
  // Carrier generator
  // ************************************************************
  logic [CNT_W-1:0] cnt_r;
  logic [CNT_W-1:0] cnt_nxt;
  logic [CNT_W:0]   low_cnt;
  logic             carrier_r;

  // Low portion is the period shifted right by one plus the duty code
  assign low_cnt = DIV_FULL >> ({1'b0, rx_ctrl_r.carrier_duty_select} + 3'h1); // RQ2
  assign cnt_nxt = (cnt_r == CNT_LAST) ? CNT_ZERO : cnt_r + CNT_ONE;         // RQ10

  // Divider counter and carrier level
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_r     <= CNT_ZERO;
      carrier_r <= 1'b0;
    end else if (ce) begin
      cnt_r     <= cnt_nxt;
      carrier_r <= ({1'b0, cnt_r} >= low_cnt); // RQ2
    end
  end

  // ************************************************************
  // Transmit path
  // ************************************************************
  logic tx_inv;
  logic tx_mod_nxt;
  logic tx_mod_r;
  logic pin_out_nxt;
  logic pin_oe_nxt;

  // Invert first, then fill zero intervals with the carrier
  assign tx_inv     = uart_tx_data ^ tx_ctrl_r.transmit_invert;                                    // RQ7
  assign tx_mod_nxt = (tx_ctrl_r.carrier_modulation_enable && !tx_inv) ? carrier_r : tx_inv;        // RQ8 RQ9

  // Transmit pin role decode
  assign transmit_pin_as_segment = transmit_seg_map;                                                // RQ6
  assign transmit_pin_as_io      = !transmit_seg_map && tx_ctrl_r.transmit_pin_select == opc_pkg::OPC_TX_IO;
  assign pin_oe_nxt              = !transmit_seg_map && (tx_ctrl_r.transmit_pin_select != opc_pkg::OPC_TX_IO || tx_io_oe);
  always_comb begin
    pin_out_nxt = 1'b0;
    unique case (tx_ctrl_r.transmit_pin_select)
      opc_pkg::OPC_TX_IO:       pin_out_nxt = tx_io_data;            // RQ6
      opc_pkg::OPC_TX_SERIAL:   pin_out_nxt = tx_mod_nxt;            // RQ6
      opc_pkg::OPC_TX_REAL:     pin_out_nxt = real_energy_pulse;     // RQ6
      opc_pkg::OPC_TX_REACTIVE: pin_out_nxt = reactive_energy_pulse; // RQ6
    endcase
    if (transmit_seg_map) begin
      pin_out_nxt = 1'b0;
    end
  end

  // Registered transmit pin drive
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      tx_mod_r                 <= 1'b0;
      optical_transmit_pin_out <= 1'b0;
      optical_transmit_pin_oe  <= 1'b0;
    end else if (ce) begin
      tx_mod_r                 <= tx_mod_nxt;
      optical_transmit_pin_out <= pin_out_nxt;
      optical_transmit_pin_oe  <= pin_oe_nxt;
    end
  end

  // ************************************************************
  // Assertions
  // ************************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  // Bit-bang line copies the synchronised input
  bitbang_route_a: assert property (ce && rx_ctrl_r.bit_bang_select |=> bit_bang_io_line == $past(rx_sync_r)) // RQ1
    else $error("bit-bang line does not follow receive input");
  // Shortest low portion starts every period
  duty_low_a: assert property (ce && rx_ctrl_r.carrier_duty_select == 2'h3 && cnt_r == CNT_ZERO |=> !carrier_r) // RQ2
    else $error("carrier not low at start of period");
  // Half duty ends every period high
  duty_high_a: assert property (ce && rx_ctrl_r.carrier_duty_select == 2'h0 && cnt_r == CNT_LAST |=> carrier_r) // RQ2
    else $error("carrier not high at end of period");
  // Serial role never flags I/O
  rx_role_a: assert property (!receive_seg_map && !rx_ctrl_r.receive_path_disable |-> !receive_pin_as_io) // RQ3
    else $error("receive pin role wrong");
  // Serial receive sees the inverted level
  rx_invert_a: assert property (ce && rx_is_serial |=> uart_rx_data == ($past(rx_sync_r) ^ $past(rx_ctrl_r.receive_invert))) // RQ4
    else $error("serial receive inversion wrong");
  // I/O input never inverted
  io_noinvert_a: assert property (ce && receive_pin_as_io |=> receive_pin_io_data == $past(rx_sync_r)) // RQ5
    else $error("I/O input affected by inversion");
  // Segment role releases the transmit pin
  tx_segment_a: assert property (ce && transmit_seg_map |=> !optical_transmit_pin_oe) // RQ6
    else $error("segment transmit pin still driven");
  // Serial role drives the modulated signal
  tx_serial_a: assert property (ce && !transmit_seg_map && tx_ctrl_r.transmit_pin_select == opc_pkg::OPC_TX_SERIAL
                                |=> optical_transmit_pin_out == tx_mod_r && optical_transmit_pin_oe) // RQ6
    else $error("serial transmit not on pin");
  // Unmodulated transmit is the inverted input
  tx_invert_a: assert property (ce && !tx_ctrl_r.carrier_modulation_enable
                                |=> tx_mod_r == ($past(uart_tx_data) ^ $past(tx_ctrl_r.transmit_invert))) // RQ7
    else $error("transmit inversion wrong");
  // Zero intervals carry the carrier
  mod_fill_a: assert property (ce && tx_ctrl_r.carrier_modulation_enable && tx_inv == 1'b0 |=> tx_mod_r == $past(carrier_r)) // RQ8
    else $error("zero interval not modulated");
  // One intervals pass unchanged
  mod_keep_a: assert property (ce && tx_ctrl_r.carrier_modulation_enable && tx_inv |=> tx_mod_r) // RQ9
    else $error("one interval changed by modulation");
  // Divider wraps after its last count
  carrier_wrap_a: assert property (ce && cnt_r == CNT_LAST |=> cnt_r == CNT_ZERO) // RQ10
    else $error("carrier divider did not wrap");

  // ************************************************************
  // Bus, role and freeze checks
  // ************************************************************
  // Bus ready follows clock enable, wait states while frozen, and always OKAY
  ready_follow_a: assert property (hreadyout == ce)
    else $error("ready does not follow clock enable");
  resp_okay_a: assert property (!hresp)
    else $error("response not OKAY");

  // Read data stands until the next accepted read, unmapped reads zero
  rdata_hold_a: assert property (!(ce && xfer_valid && !hwrite) |=> $stable(hrdata))
    else $error("read data changed without a read");
  unmapped_read_a: assert property (ce && xfer_valid && !hwrite && !aph_nxt.tx_hit && !aph_nxt.rx_hit
                                    |=> hrdata == opc_pkg::RDATA_ZERO)
    else $error("unmapped read not zero");

  // Register writes land in the data phase, written fields take the bus write data
  tx_write_a: assert property (ce && aph_r.wr && aph_r.tx_hit |=> tx_ctrl_r[3:0] == $past(hwdata[3:0])) // RQ7
    else $error("transmit control write lost");
  rx_write_a: assert property (ce && aph_r.wr && aph_r.rx_hit // RQ4
                               |=> rx_ctrl_r[5:4] == $past(hwdata[5:4]) && rx_ctrl_r[2:0] == $past(hwdata[2:0]))
    else $error("receive control write lost");

  // Receive roles and idle levels
  rx_segment_a: assert property (receive_seg_map |-> receive_pin_as_segment && !receive_pin_as_io) // RQ3
    else $error("receive segment role wrong");
  rx_io_role_a: assert property (!receive_seg_map && rx_ctrl_r.receive_path_disable |-> receive_pin_as_io) // RQ3
    else $error("receive I/O role missing");
  rx_idle_a: assert property (ce && !rx_is_serial |=> !uart_rx_data) // RQ4
    else $error("serial receive active outside its role");
  io_idle_a: assert property (ce && !receive_pin_as_io |=> !receive_pin_io_data) // RQ5
    else $error("I/O input active outside its role");
  bitbang_off_a: assert property (ce && !rx_ctrl_r.bit_bang_select |=> !bit_bang_io_line) // RQ1
    else $error("bit-bang line active while not selected");
  rx_sync_a: assert property (ce |=> rx_sync_r == $past(rx_meta_r))
    else $error("receive synchroniser skipped a stage");

  // Transmit roles
  tx_seg_low_a: assert property (ce && transmit_seg_map |=> !optical_transmit_pin_out) // RQ6
    else $error("segment transmit pin level not low");
  tx_io_a: assert property (ce && transmit_pin_as_io // RQ6
                            |=> optical_transmit_pin_out == $past(tx_io_data) && optical_transmit_pin_oe == $past(tx_io_oe))
    else $error("transmit I/O role wrong");
  tx_real_a: assert property (ce && !transmit_seg_map && tx_ctrl_r.transmit_pin_select == opc_pkg::OPC_TX_REAL // RQ6
                              |=> optical_transmit_pin_out == $past(real_energy_pulse) && optical_transmit_pin_oe)
    else $error("real pulse not on pin");
  tx_reactive_a: assert property (ce && !transmit_seg_map && tx_ctrl_r.transmit_pin_select == opc_pkg::OPC_TX_REACTIVE // RQ6
                                  |=> optical_transmit_pin_out == $past(reactive_energy_pulse) && optical_transmit_pin_oe)
    else $error("reactive pulse not on pin");
  inv_mod_a: assert property (ce && tx_ctrl_r.carrier_modulation_enable && tx_ctrl_r.transmit_invert && uart_tx_data // RQ8
                              |=> tx_mod_r == $past(carrier_r))
    else $error("inverted one not modulated");

  // Carrier duty edges, divider step and freeze
  duty_quarter_a: assert property (ce && rx_ctrl_r.carrier_duty_select == 2'h1 // RQ2
                                   && cnt_r == CNT_W'(CARRIER_DIV / 4 - 1) |=> !carrier_r)
    else $error("quarter duty low portion too short");
  duty_quarter_hi_a: assert property (ce && rx_ctrl_r.carrier_duty_select == 2'h1 // RQ2
                                      && cnt_r == CNT_W'(CARRIER_DIV / 4) |=> carrier_r)
    else $error("quarter duty low portion too long");
  duty_eighth_a: assert property (ce && rx_ctrl_r.carrier_duty_select == 2'h2 // RQ2
                                  && cnt_r == CNT_W'(CARRIER_DIV / 8) |=> carrier_r)
    else $error("eighth duty low portion too long");
  carrier_step_a: assert property (ce && cnt_r != CNT_LAST |=> cnt_r == $past(cnt_r) + CNT_ONE) // RQ10
    else $error("carrier divider skipped a count");
  freeze_a: assert property (!ce |=> $stable(cnt_r) && $stable(tx_ctrl_r) && $stable(optical_transmit_pin_out))
    else $error("state changed while clock enable low");

  // Cover points for the main scenarios
  mod_on_c: cover property (ce && tx_ctrl_r.carrier_modulation_enable && !tx_inv ##1 carrier_r);
  bitbang_c: cover property (rx_ctrl_r.bit_bang_select && bit_bang_io_line);
  reg_write_c: cover property (ce && aph_r.wr && aph_r.rx_hit);
  freeze_c: cover property (!ce ##1 ce);
  pulse_role_c: cover property (ce && !transmit_seg_map && tx_ctrl_r.transmit_pin_select == opc_pkg::OPC_TX_REAL);

endmodule

// file: hdl/opc_pkg.sv
// Package of constants and types for the optical port configuration block
package opc_pkg;

  // ************************************************************
  // Register map (printed offsets are word indices)
  // ************************************************************
  localparam int          ADDR_W       = 16;
  localparam logic [15:0] TX_CTRL_IDX  = 16'h2456;
  localparam logic [15:0] RX_CTRL_IDX  = 16'h2457;
  localparam logic [15:0] TX_CTRL_ADDR = 16'((32'(TX_CTRL_IDX)) * 4);
  localparam logic [15:0] RX_CTRL_ADDR = 16'((32'(RX_CTRL_IDX)) * 4);
  localparam logic [7:0]  CTRL_RESET   = 8'h00;

  // ************************************************************
  // Bus encodings
  // ************************************************************
  localparam logic [1:0]  HTRANS_NONSEQ = 2'h2;
  localparam logic [1:0]  HTRANS_SEQ    = 2'h3;
  localparam logic [2:0]  HSIZE_WORD    = 3'h2;
  localparam logic [1:0]  ADDR_LSB_ZERO = 2'h0;
  localparam logic [31:0] RDATA_ZERO    = 32'h0000_0000;

  // ************************************************************
  // Transmit pin roles
  // ************************************************************
  typedef enum logic [1:0] {
    OPC_TX_IO       = 2'b00,
    OPC_TX_SERIAL   = 2'b01,
    OPC_TX_REAL     = 2'b10,
    OPC_TX_REACTIVE = 2'b11
  } opc_tx_sel_t;

  // Transmit control fields, bits 7:0 of the word
  typedef struct packed {
    logic [3:0]  rsvd;
    opc_tx_sel_t transmit_pin_select;
    logic        carrier_modulation_enable;
    logic        transmit_invert;
  } opc_tx_ctrl_t;

  // Receive control fields, bits 7:0 of the word
  typedef struct packed {
    logic [1:0] rsvd_hi;
    logic [1:0] carrier_duty_select;
    logic       rsvd_lo;
    logic       receive_path_disable;
    logic       receive_invert;
    logic       bit_bang_select;
  } opc_rx_ctrl_t;

  // Registered address phase of a bus transfer
  typedef struct packed {
    logic              wr;
    logic              tx_hit;
    logic              rx_hit;
  } opc_aphase_t;

endpackage

// file: verification/opc_ir_partner.sv
// Behavioural model of the optical receive comparator and infrared LED driver
`timescale 1ns/10ps
module opc_ir_partner (
  input  wire logic clk,                  // System clock
  input  wire logic rx_light,             // Light level falling on the receiver
  output logic      optical_receive_pin,  // Comparator output
  input  wire logic tx_level,             // Transmit pin level
  input  wire logic tx_oe,                // Transmit pin drive enable
  output logic      led_on                // LED lit
);
  // Comparator settles one clock after the light changes
  always_ff @(posedge clk) begin
    optical_receive_pin <= rx_light;
  end

  // LED only lights while the pin is driven high
  assign led_on = tx_oe & tx_level;
endmodule

// file: verification/optical_port_config_tb.sv
// Self-checking testbench for the optical port configuration block
`timescale 1ns/10ps
module optical_port_config_tb;
  localparam int DIV = 16;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        ce = 1'b1;
  logic        hsel = 1'b0;
  logic [15:0] haddr = 16'h0000;
  logic [1:0]  htrans = 2'h0;
  logic        hwrite = 1'b0;
  logic [2:0]  hsize = 3'h2;
  logic [31:0] hwdata = 32'h0000_0000;
  logic        hready;
  logic        hreadyout, hresp, optical_receive_pin;
  logic [31:0] hrdata, rdv, cnt;
  logic        rx_light = 1'b0, receive_seg_map = 1'b0, transmit_seg_map = 1'b0;
  logic        uart_tx_data = 1'b0, real_energy_pulse = 1'b0, reactive_energy_pulse = 1'b0;
  logic        tx_io_data = 1'b0, tx_io_oe = 1'b0;
  logic        uart_rx_data, receive_pin_io_data, bit_bang_io_line, receive_pin_as_segment;
  logic        receive_pin_as_io, transmit_pin_as_segment, transmit_pin_as_io;
  logic        optical_transmit_pin_out, optical_transmit_pin_oe;
  logic        s, d, v, p, b, eo, eoe;
  logic [1:0]  sel;
  int          err_total = 0;
  int          comparisons = 0;

  // ************************************************************
  // Clock, bus ready and instances
  // ************************************************************
  always #20 clk = ~clk;
  assign hready = hreadyout;

  opc_optical_port #(.CARRIER_DIV(DIV)) opc_optical_port_inst (
    .clk, .rst, .ce, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready, .hreadyout, .hresp, .hrdata,
    .optical_receive_pin, .receive_seg_map, .transmit_seg_map, .uart_tx_data, .real_energy_pulse,
    .reactive_energy_pulse, .tx_io_data, .tx_io_oe, .uart_rx_data, .receive_pin_io_data, .bit_bang_io_line,
    .receive_pin_as_segment, .receive_pin_as_io, .transmit_pin_as_segment, .transmit_pin_as_io,
    .optical_transmit_pin_out, .optical_transmit_pin_oe);

  opc_ir_partner opc_ir_partner_inst (
    .clk, .rx_light, .optical_receive_pin, .tx_level(optical_transmit_pin_out),
    .tx_oe(optical_transmit_pin_oe), .led_on());

  // ************************************************************
  // Bus transfer and compare tasks
  // ************************************************************
  // One single word transfer; address phase held until ready
  task automatic bus(input logic wr, input logic [15:0] a, input logic [31:0] dat, output logic [31:0] q);
    @(posedge clk);
    haddr <= a;
    hwrite <= wr;
    htrans <= opc_pkg::HTRANS_NONSEQ;
    hsize <= opc_pkg::HSIZE_WORD;
    hsel <= 1'b1;
    do @(posedge clk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= dat;
    do @(posedge clk); while (hreadyout !== 1'b1);
    q = hrdata;
  endtask

  task automatic chk_bit(input logic got, input logic exp);
    comparisons++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic give_verdict;
    if (err_total == 0 && comparisons > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  // ************************************************************
  // Test sequence
  // ************************************************************
  initial begin
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    // Reset values, reserved bits and an unmapped word
    bus(1'b0, opc_pkg::TX_CTRL_ADDR, 32'h0, rdv);
    chk_word(rdv, {24'h0, opc_pkg::CTRL_RESET});
    bus(1'b0, opc_pkg::RX_CTRL_ADDR, 32'h0, rdv);
    chk_word(rdv, {24'h0, opc_pkg::CTRL_RESET});
    bus(1'b1, opc_pkg::TX_CTRL_ADDR, 32'hffff_ffff, rdv);
    bus(1'b1, opc_pkg::RX_CTRL_ADDR, 32'hffff_ffff, rdv);
    bus(1'b1, 16'h9160, 32'hffff_ffff, rdv);
    bus(1'b0, opc_pkg::TX_CTRL_ADDR, 32'h0, rdv);
    chk_word(rdv, 32'h0000_000f);
    bus(1'b0, opc_pkg::RX_CTRL_ADDR, 32'h0, rdv);
    chk_word(rdv, 32'h0000_0037);
    bus(1'b0, 16'h9160, 32'h0, rdv);
    chk_word(rdv, 32'h0000_0000);
    chk_bit(hresp, 1'b0);
    // Receive roles, inversion and bit-bang routing
    for (int k = 0; k < 16; k++) begin
      s = k[0];
      d = k[1];
      v = k[2];
      p = k[3];
      b = k[1] ^ k[2];
      receive_seg_map <= s;
      rx_light <= p;
      bus(1'b1, opc_pkg::RX_CTRL_ADDR, {29'h0, d, v, b}, rdv);
      repeat (6) @(posedge clk);
      chk_bit(receive_pin_as_segment, s);
      chk_bit(receive_pin_as_io, !s & d);
      chk_bit(uart_rx_data, !s & !d & (p ^ v));
      chk_bit(receive_pin_io_data, !s & d & p);
      chk_bit(bit_bang_io_line, b & p);
    end
    // Transmit roles and inversion, modulation off
    for (int k = 0; k < 32; k++) begin
      sel = k[1:0];
      s = k[2];
      v = (sel == 2'b01) ? k[3] : 1'b0;
      p = k[4];
      transmit_seg_map <= s;
      uart_tx_data <= p;
      real_energy_pulse <= p;
      reactive_energy_pulse <= ~p;
      tx_io_data <= p;
      tx_io_oe <= k[3];
      bus(1'b1, opc_pkg::TX_CTRL_ADDR, {28'h0, sel, 1'b0, v}, rdv);
      repeat (3) @(posedge clk);
      eoe = !s & ((sel != 2'b00) | k[3]);
      eo = (sel == 2'b11) ? ~p : p ^ v;
      chk_bit(transmit_pin_as_segment, s);
      chk_bit(transmit_pin_as_io, !s & (sel == 2'b00));
      chk_bit(optical_transmit_pin_oe, eoe);
      chk_bit(optical_transmit_pin_out, s ? 1'b0 : eo);
    end
    // Carrier duty over two periods, inversion ahead of modulation
    transmit_seg_map <= 1'b0;
    for (int k = 0; k < 16; k++) begin
      v = k[2];
      uart_tx_data <= k[3];
      bus(1'b1, opc_pkg::RX_CTRL_ADDR, {26'h0, k[1:0], 4'h0}, rdv);
      bus(1'b1, opc_pkg::TX_CTRL_ADDR, {28'h0, 2'b01, 1'b1, v}, rdv);
      repeat (4) @(posedge clk);
      cnt = 32'h0;
      repeat (2 * DIV) begin
        @(posedge clk);
        cnt = cnt + {31'h0, ~optical_transmit_pin_out};
      end
      chk_word(cnt, (k[3] ^ v) ? 32'h0 : 32'((2 * DIV) >> (k % 4 + 1)));
    end
    // Clock enable low freezes the carrier and stalls the bus
    ce <= 1'b0;
    repeat (2) @(posedge clk);
    eo = optical_transmit_pin_out;
    repeat (DIV) @(posedge clk);
    chk_bit(hreadyout, 1'b0);
    chk_bit(optical_transmit_pin_out, eo);
    ce <= 1'b1;
    repeat (2) @(posedge clk);
    chk_bit(hreadyout, 1'b1);
    chk_bit(hresp, 1'b0);
    give_verdict();
  end

  // Watchdog against a hung handshake
  initial begin
    repeat (5000) @(posedge clk);
    err_total++;
    give_verdict();
  end
endmodule
